// ---- design/uart_pkg.sv ----
// constants, register layouts and types shared by the two-frame uart
package uart_pkg;
   // register byte offsets
   localparam int unsigned AXI_ADDR_W = 8;
   localparam logic [7:0]  OFF_MODE_A = 8'h00;
   localparam logic [7:0]  OFF_MODE_B = 8'h04;
   localparam logic [7:0]  OFF_BAUD   = 8'h08;
   localparam logic [7:0]  OFF_TX     = 8'h0C;
   localparam logic [7:0]  OFF_RX     = 8'h10;
   localparam logic [7:0]  OFF_STATUS = 8'h14;
   // axi responses
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   // bit timing: 16 serial clocks per bit, mid start bit after 8
   localparam int unsigned BAUD_W       = 16;
   localparam logic [15:0] BAUD_DIV_RST = 16'h0082;
   localparam logic [3:0]  SUB_LAST     = 4'hF;
   localparam logic [3:0]  MID_LAST     = 4'h7;
   localparam int unsigned FRAME_MAX    = 12;
   // interrupt shaping in system clocks: rise after 2, high for 2
   localparam int unsigned IRQ_DELAY = 2;
   localparam int unsigned IRQ_HIGH  = 2;
   localparam int unsigned IRQ_PIPE  = IRQ_DELAY + IRQ_HIGH - 1;
   // parity encodings {high, low}
   localparam logic [1:0] PAR_ZERO = 2'b01;
   localparam logic [1:0] PAR_ODD  = 2'b10;
   localparam logic [1:0] PAR_EVEN = 2'b11;

   typedef struct packed {
      logic receive_enable_bit;
      logic stop_length_select;
      logic parity_mode_bit_high;
      logic parity_mode_bit_low;
      logic char_width_select;
   } mode_a_t;

   typedef struct packed {
      logic two_frame_select;
      logic extension_bit_enable;
      logic clocked_operation_select;
   } mode_b_t;

   typedef struct packed {
      logic overrun;
      logic framing_err;
      logic parity_err;
      logic rx_full;
      logic rx_busy;
      logic tx_busy;
   } status_t;

   localparam mode_a_t MODE_A_RST = 5'h00;
   localparam mode_b_t MODE_B_RST = 3'h0;

   typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_t;
   typedef enum logic [1:0] {
      RX_IDLE   = 2'b00,
      RX_VERIFY = 2'b01,
      RX_DATA   = 2'b10
   } rx_state_t;
endpackage

// ---- design/baud_tick_gen.sv ----
// serial clock generator: one tick every divisor system clocks
`timescale 1ns/1ps
module baud_tick_gen #(
   parameter int unsigned W = 16
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // divisor and tick
   input  wire logic [W-1:0] divisor,
   output logic              tick
);
   logic [W-1:0] count;

   // a zero divisor behaves as one so the tick never stops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (divisor == '0 || count >= divisor - W'(1)) begin
         count <= '0;
         tick  <= 1'b1;
      end else begin
         count <= count + W'(1);
         tick  <= 1'b0;
      end
   end
endmodule // baud_tick_gen

// ---- design/uart_two_frame_serial.sv ----
// two-frame uart core with an axi4-lite register slave
`timescale 1ns/1ps
// Contract
// - frame is start, chars, parity, stops
// - characters travel least significant bit first
// - width bit picks seven or eight characters
// - stop select gives one or two stops
// - extension adds ninth bit, eight bits, no parity; ignored here in two-frame mode
// - transmit write starts frame at next shift
// - transmitter adds start, parity, stop bits
// - done interrupt with last stop bit output
// - line stays high idle until next write
// - reset never raises the done interrupt
// - writes during transfer are ignored
// - interrupt rises two clocks, falls two later
// - late data gets one high idle bit
// - enable waits start; disable holds, keeps buffer
// - receive done per one or two frames
// - async start confirmed eight clocks after edge
// - high re-sample rejects edge, stops counter
// - clocked mode takes low sample as start
// - stuck low finishes character, no restart
// - receive done also raised on errors
// - receiver checks exactly one stop bit
module uart_two_frame_serial
   import uart_pkg::*;
#(
   parameter logic [BAUD_W-1:0] BAUD_DIV_DEFAULT = BAUD_DIV_RST
) (
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite write
   input  wire logic [AXI_ADDR_W-1:0] awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   // axi4-lite read
   input  wire logic [AXI_ADDR_W-1:0] araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // serial line and interrupts
   input  wire logic                  serial_in_pin,
   output logic                       serial_out_pin,
   output logic                       tx_done_irq,
   output logic                       rx_done_irq
);
   mode_a_t               mode_a;
   mode_b_t               mode_b;
   logic [BAUD_W-1:0]     baud_div;
   logic [AXI_ADDR_W-1:0] aw_addr;
   logic [31:0]           w_data;
   logic [3:0]            w_strb;
   logic                  wr_fire;
   logic                  rd_fire;
   logic [31:0]           next_rdata;
   logic                  next_rd_err;
   logic                  wr_err;
   logic                  sample_tick;
   status_t               status;
   logic                  st_full;
   logic                  st_perr;
   logic                  st_ferr;
   logic                  st_ovr;
   // transmit side
   tx_state_t             tx_state;
   logic [FRAME_MAX-1:0]  tx_shift;
   logic [3:0]            tx_left;
   logic [3:0]            tx_sub;
   logic                  tx_tick;
   logic                  tx_second;
   logic                  tx_pending;
   logic                  tx_recent;
   logic                  tx_busy;
   logic                  tx_evt;
   logic [15:0]           tx_data;
   logic                  tx_wr_req;
   logic [8:0]            load_data;
   logic                  ext_eff;
   logic [FRAME_MAX-1:0]  next_frame;
   logic [3:0]            next_len;
   logic [IRQ_PIPE-1:0]   tx_pipe;
   // receive side
   rx_state_t             rx_state;
   logic                  rx_meta;
   logic                  rx_sync;
   logic                  rx_prev;
   logic                  rx_armed;
   logic [3:0]            rx_cnt;
   logic [3:0]            rx_idx;
   logic [3:0]            rx_last;
   logic [9:0]            rx_word;
   logic [8:0]            rx_char;
   logic                  rx_second;
   logic [15:0]           rx_buf;
   logic                  rx_done_frame;
   logic                  rx_perr;
   logic                  rx_ferr;
   logic                  rx_complete;
   logic                  rx_evt;
   logic [IRQ_PIPE-1:0]   rx_pipe;

   function automatic logic parity_on(input mode_a_t a);
      return a.parity_mode_bit_high | a.parity_mode_bit_low;
   endfunction

   function automatic logic [3:0] char_bits(input mode_a_t a, input logic ext);
      if (!a.char_width_select)
         return 4'h7;
      else if (ext && !parity_on(a))
         return 4'h9;
      else
         return 4'h8;
   endfunction

   function automatic logic [3:0] frame_len(input mode_a_t a, input logic ext);
      return 4'h2 + char_bits(a, ext) + {3'h0, parity_on(a)} + {3'h0, a.stop_length_select};
   endfunction

   // start bit, lsb-first characters, parity, then stops as idle ones
   function automatic logic [FRAME_MAX-1:0] build_frame(input logic [8:0] d,
                                                         input mode_a_t a,
                                                         input logic ext);
      logic [FRAME_MAX-1:0] f;
      logic [3:0]           w;
      logic                 ones;
      f    = '1;
      w    = char_bits(a, ext);
      ones = 1'b0;
      f[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < w) begin
            f[i+1] = d[i];
            ones   = ones ^ d[i];
         end
      end
      if (parity_on(a)) begin
         case ({a.parity_mode_bit_high, a.parity_mode_bit_low})
            PAR_EVEN: f[w+1] = ones;
            PAR_ODD:  f[w+1] = ~ones;
            default:  f[w+1] = 1'b0;
         endcase
      end
      return f;
   endfunction

   baud_tick_gen #(.W(BAUD_W)) u_baud (
      .aclk    (aclk),
      .aresetn (aresetn),
      .divisor (baud_div),
      .tick    (sample_tick)
   );

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // write channel: address and data held until both are in
   assign wr_fire   = !awready && !wready && !bvalid;
   assign tx_wr_req = wr_fire && aw_addr == OFF_TX && w_strb[0];
   assign wr_err    = !(aw_addr == OFF_MODE_A || aw_addr == OFF_MODE_B ||
                        aw_addr == OFF_BAUD || aw_addr == OFF_TX);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (wr_fire) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b1;
            bresp   <= wr_err ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_a   <= MODE_A_RST;
         mode_b   <= MODE_B_RST;
         baud_div <= BAUD_DIV_DEFAULT;
      end else if (wr_fire) begin
         if (aw_addr == OFF_MODE_A && w_strb[0])
            mode_a <= w_data[4:0];
         if (aw_addr == OFF_MODE_B && w_strb[0])
            mode_b <= w_data[2:0];
         if (aw_addr == OFF_BAUD && w_strb[0])
            baud_div[7:0] <= w_data[7:0];
         if (aw_addr == OFF_BAUD && w_strb[1])
            baud_div[15:8] <= w_data[15:8];
      end
   end

   // read channel
   assign rd_fire = arvalid && arready;
   assign status  = '{overrun: st_ovr, framing_err: st_ferr,
                      parity_err: st_perr, rx_full: st_full,
                      rx_busy: rx_state != RX_IDLE, tx_busy: tx_busy};

   always_comb begin
      next_rdata  = '0;
      next_rd_err = 1'b0;
      case (araddr)
         OFF_MODE_A: next_rdata = {27'h000_0000, mode_a};
         OFF_MODE_B: next_rdata = {29'h0000_0000, mode_b};
         OFF_BAUD:   next_rdata = {16'h0000, baud_div};
         OFF_TX:     next_rdata = '0;
         OFF_RX:     next_rdata = {16'h0000, rx_buf};
         OFF_STATUS: next_rdata = {26'h000_0000, status};
         default:    next_rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (rd_fire) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= next_rdata;
         rresp   <= next_rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // transmit: frame chosen from the live mode bits at each load
   assign tx_tick    = sample_tick && tx_sub == SUB_LAST;
   assign ext_eff    = mode_b.extension_bit_enable && !mode_b.two_frame_select;
   assign load_data  = tx_second ? {1'b0, tx_data[15:8]} :
                       (mode_b.two_frame_select ? {1'b0, tx_data[7:0]} : tx_data[8:0]);
   assign next_frame = build_frame(load_data, mode_a, ext_eff);
   assign next_len   = frame_len(mode_a, ext_eff);

   always_ff @(posedge aclk) begin
      if (!aresetn)
         tx_sub <= '0;
      else if (sample_tick)
         tx_sub <= tx_sub + 4'h1;
   end

   // write taken only once the previous done pulse has fallen
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_busy <= 1'b0;
         tx_data <= '0;
      end else if (tx_wr_req && !tx_busy) begin
         tx_busy <= 1'b1;
         tx_data <= w_strb[1] ? w_data[15:0] : {8'h00, w_data[7:0]};
      end else if (tx_pipe[IRQ_PIPE-1]) begin
         tx_busy <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state       <= TX_IDLE;
         tx_shift       <= '1;
         tx_left        <= '0;
         tx_second      <= 1'b0;
         tx_pending     <= 1'b0;
         tx_recent      <= 1'b0;
         tx_evt         <= 1'b0;
         serial_out_pin <= 1'b1;
      end else begin
         tx_evt <= 1'b0;
         if (tx_wr_req && !tx_busy)
            tx_pending <= 1'b1;
         if (tx_tick) begin
            if (tx_state == TX_SHIFT && tx_left != '0) begin
               tx_shift       <= {1'b1, tx_shift[FRAME_MAX-1:1]};
               serial_out_pin <= tx_shift[1];
               tx_left        <= tx_left - 4'h1;
               tx_evt         <= tx_left == 4'h1 && !tx_second;
            end else if ((tx_state == TX_SHIFT && tx_second) ||
                         (tx_pending && !(tx_state == TX_IDLE && tx_recent))) begin
               tx_state       <= TX_SHIFT;
               tx_shift       <= next_frame;
               serial_out_pin <= next_frame[0];
               tx_left        <= next_len - 4'h1;
               tx_second      <= !tx_second && mode_b.two_frame_select;
               tx_recent      <= 1'b0;
               if (!tx_second)
                  tx_pending <= 1'b0;
            end else begin
               // late data costs one whole high bit after the last stop
               tx_recent      <= tx_state == TX_SHIFT;
               tx_state       <= TX_IDLE;
               serial_out_pin <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_pipe     <= '0;
         tx_done_irq <= 1'b0;
      end else begin
         tx_pipe     <= {tx_pipe[IRQ_PIPE-2:0], tx_evt};
         tx_done_irq <= |tx_pipe[IRQ_DELAY-2 +: IRQ_HIGH];
      end
   end

   a_idle_line_high: assert property (tx_state == TX_IDLE |-> serial_out_pin)
      else $error("line not high while transmitter idle");
   a_start_bit_low: assert property (
      $rose(tx_state == TX_SHIFT) |-> !serial_out_pin && tx_left == next_len - 4'h1)
      else $error("frame did not open with a low start bit");
   a_done_on_stop: assert property (
      tx_evt |-> serial_out_pin && tx_left == 4'h0 && !tx_second)
      else $error("done event not on the final stop bit");
   a_irq_timing: assert property (
      tx_evt |-> ##1 !tx_done_irq ##1 tx_done_irq [*2] ##1 !tx_done_irq)
      else $error("done interrupt shape wrong");
   a_busy_until_fall: assert property ($fell(tx_done_irq) |-> !tx_busy && $past(tx_busy))
      else $error("transmit busy not released at interrupt fall");
   a_write_ignored: assert property (
      tx_busy && tx_wr_req && !tx_tick |=> $stable(tx_data) && $stable(tx_second))
      else $error("busy write disturbed the transfer");
   a_gap_bit: assert property (tx_recent && tx_tick |=> tx_state == TX_IDLE)
      else $error("no idle bit before late frame");

   // receive: two-flop synchroniser, rx_meta read only by rx_sync
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= serial_in_pin;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end

   assign rx_last       = char_bits(mode_a, ext_eff) + {3'h0, parity_on(mode_a)};
   assign rx_done_frame = rx_state == RX_DATA && sample_tick && rx_cnt == SUB_LAST &&
                          rx_idx == rx_last && mode_a.receive_enable_bit;
   assign rx_ferr       = !rx_sync;
   assign rx_complete   = !mode_b.two_frame_select || rx_second;

   always_comb begin
      rx_char = '0;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < char_bits(mode_a, ext_eff))
            rx_char[i] = rx_word[i];
      end
      case ({mode_a.parity_mode_bit_high, mode_a.parity_mode_bit_low})
         PAR_EVEN: rx_perr = ^rx_char ^ rx_word[char_bits(mode_a, ext_eff)];
         PAR_ODD:  rx_perr = ~(^rx_char ^ rx_word[char_bits(mode_a, ext_eff)]);
         default:  rx_perr = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_state  <= RX_IDLE;
         rx_cnt    <= '0;
         rx_idx    <= '0;
         rx_word   <= '0;
         rx_armed  <= 1'b0;
         rx_second <= 1'b0;
         rx_evt    <= 1'b0;
      end else begin
         rx_evt <= 1'b0;
         if (rx_sync)
            rx_armed <= 1'b1;
         if (!mode_a.receive_enable_bit) begin
            rx_state  <= RX_IDLE;
            rx_cnt    <= '0;
            rx_second <= 1'b0;
         end else begin
            case (rx_state)
               RX_IDLE: begin
                  rx_cnt <= '0;
                  rx_idx <= '0;
                  if (rx_armed && !mode_b.clocked_operation_select && rx_prev && !rx_sync)
                     rx_state <= RX_VERIFY;
                  else if (rx_armed && mode_b.clocked_operation_select && sample_tick && !rx_sync) begin
                     rx_state <= RX_DATA;
                     rx_armed <= 1'b0;
                  end
               end
               RX_VERIFY: begin
                  if (sample_tick && rx_cnt == MID_LAST) begin
                     rx_cnt   <= '0;
                     rx_state <= rx_sync ? RX_IDLE : RX_DATA;
                     rx_armed <= rx_sync;
                  end else if (sample_tick)
                     rx_cnt <= rx_cnt + 4'h1;
               end
               RX_DATA: begin
                  if (sample_tick)
                     rx_cnt <= rx_cnt + 4'h1;
                  if (rx_done_frame) begin
                     rx_state  <= RX_IDLE;
                     rx_second <= mode_b.two_frame_select && !rx_second;
                     rx_evt    <= rx_complete || rx_perr || rx_ferr;
                  end else if (sample_tick && rx_cnt == SUB_LAST) begin
                     rx_word[rx_idx] <= rx_sync;
                     rx_idx          <= rx_idx + 4'h1;
                  end
               end
               default: rx_state <= RX_IDLE;
            endcase
         end
      end
   end

   // buffer survives disable; error flags: set wins over read clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_buf  <= '0;
         st_full <= 1'b0;
         st_perr <= 1'b0;
         st_ferr <= 1'b0;
         st_ovr  <= 1'b0;
      end else begin
         if (rd_fire && araddr == OFF_RX)
            st_full <= 1'b0;
         if (rd_fire && araddr == OFF_STATUS) begin
            st_perr <= 1'b0;
            st_ferr <= 1'b0;
            st_ovr  <= 1'b0;
         end
         if (rx_done_frame) begin
            rx_buf <= mode_b.two_frame_select ? {rx_buf[7:0], rx_char[7:0]} :
                                                {7'h00, rx_char};
            if (rx_perr)
               st_perr <= 1'b1;
            if (rx_ferr)
               st_ferr <= 1'b1;
            if (rx_complete && st_full)
               st_ovr <= 1'b1;
            if (rx_complete)
               st_full <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_pipe     <= '0;
         rx_done_irq <= 1'b0;
      end else begin
         rx_pipe     <= {rx_pipe[IRQ_PIPE-2:0], rx_evt};
         rx_done_irq <= |rx_pipe[IRQ_DELAY-2 +: IRQ_HIGH];
      end
   end

   a_reject_edge: assert property (
      rx_state == RX_VERIFY && sample_tick && rx_cnt == MID_LAST && rx_sync
      |=> rx_state == RX_IDLE && rx_cnt == 4'h0)
      else $error("high re-sample did not reject the edge");
   a_rx_quiet_off: assert property (
      !mode_a.receive_enable_bit |=> rx_state == RX_IDLE && !rx_evt && $stable(rx_buf))
      else $error("receiver active while disabled");
   a_no_restart_low: assert property (rx_state == RX_IDLE && !rx_armed |=> rx_state == RX_IDLE)
      else $error("start search while line still low");
   a_rx_irq_timing: assert property (rx_evt |-> ##2 rx_done_irq ##2 !rx_done_irq)
      else $error("receive interrupt shape wrong");
endmodule // uart_two_frame_serial

// ---- test/remote_xcvr.sv ----
// remote serial transceiver driving the receive line
`timescale 1ns/1ps
module remote_xcvr (
   // clock and line
   input  wire logic aclk,
   output logic      line
);
   initial line = 1'b1; // pulled high between frames
   task automatic send(input logic [7:0] d, input int bc);
      logic [9:0] f;
      f = {1'b1, d, 1'b0}; // start, data, one stop
      for (int i = 0; i < 10; i++) begin
         line <= f[i]; // lsb first
         repeat (bc) @(posedge aclk);
      end
   endtask
endmodule // remote_xcvr

// ---- test/uart_two_frame_serial_tb.sv ----
// self-checking bench for the two-frame uart
`timescale 1ns/1ps
module uart_two_frame_serial_tb;
   import uart_pkg::*;
   localparam int BC = 32; // divisor 2: sixteen ticks per bit
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic serial_in_pin, serial_out_pin, tx_done_irq, rx_done_irq;
   logic [7:0]  awaddr, araddr, r;
   logic [31:0] wdata, rdata, rd, seed;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   logic [8:0]  expq[$];
   int          fail_count, num_checks, q;
   uart_two_frame_serial dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .serial_in_pin, .serial_out_pin, .tx_done_irq, .rx_done_irq);
   remote_xcvr peer (.aclk, .line(serial_in_pin));
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic hit(ref logic s);
      int n;
      for (n = 0; n < 2000 && s !== 1'b1; n++) @(posedge aclk);
      if (n == 2000) begin
         fail_count++;
         stop_test();
      end
   endtask
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // each channel released at its own handshake edge
   task automatic wr(logic [7:0] a, logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            chk("bresp", RESP_OKAY, bresp);
            break;
         end
      end
      bready <= 1'b0;
      if (n == 2000) begin
         fail_count++;
         stop_test();
      end
   endtask
   task automatic rdr(logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rd = rdata;
            rs = rresp;
            break;
         end
      end
      rready <= 1'b0;
      if (n == 2000) begin
         fail_count++;
         stop_test();
      end
   endtask
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // frames on the transmit line, judged against the oldest note
   initial begin : mon
      logic [8:0] f;
      forever begin
         @(negedge serial_out_pin);
         repeat (BC / 2) @(posedge aclk);
         for (int i = 0; i < 9; i++) begin
            repeat (BC) @(posedge aclk);
            f[i] = serial_out_pin;
         end
         if (expq.size() == 0)
            chk("tx extra frame", 0, 1);
         else
            chk("tx frame", expq.pop_front(), f);
      end
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'h3;
      seed = 32'h0000_71dd;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      chk("idle line", 1, serial_out_pin);
      chk("tx irq", 0, tx_done_irq);
      wr(OFF_BAUD, 32'h0000_0002);
      wr(OFF_MODE_A, 32'h0000_0011);
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         r = seed[15:8];
         expq.push_back({1'b1, seed[7:0]});
         wr(OFF_TX, {24'h0, seed[7:0]});
         wr(OFF_TX, {24'h0, ~seed[7:0]});
         fork
            peer.send(r, BC);
            hit(rx_done_irq);
            begin
               hit(tx_done_irq);
               @(posedge aclk);
               chk("irq second", 1, tx_done_irq);
               @(posedge aclk);
               chk("irq fall", 0, tx_done_irq);
            end
         join
         rdr(OFF_RX);
         chk("rx data", {24'h0, r}, rd);
      end
      wr(OFF_MODE_A, 32'h0000_0001);
      q = 0;
      fork
         peer.send(8'ha5, BC);
         repeat (BC * 11) @(posedge aclk) q += (rx_done_irq === 1'b1);
      join
      chk("rx off irq", 0, q);
      rdr(OFF_RX);
      chk("rx held", {24'h0, r}, rd);
      rdr(8'h18);
      chk("unmapped resp", RESP_SLVERR, rs);
      chk("unmapped data", 0, rd);
      stop_test();
   end
endmodule // uart_two_frame_serial_tb
